// ==== dv/amp_ctrl_checker.sv ====
// Purpose: port-level assertions for the amplifier control block
// Assumes: zero-wait APB slave, single clock
// Notes:   bound into the top module after endmodule
module amp_ctrl_checker
  import amp_ctrl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        dacOut1Enable,
  input wire logic        amp1Enable,
  input wire gain_oh_t    amp1GainSel,
  input wire gain_oh_t    amp2GainSel,
  input wire sel_oh_t     amp1PosInSel,
  input wire sel_oh_t     amp1NegInSel,
  input wire logic        amp1NegGround,
  input wire trim_t       amp1OffsetTrim,
  input wire logic        amp2ToPin1Switch,
  input wire logic        amp2ToPin2Switch,
  input wire logic        dacToPin1Switch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic wrEn1;
  logic wrT1;
  assign wr = psel && penable && pwrite;
  assign wrEn1 = wr && paddr == 12'h000 && pstrb[1] && pwdata[15];
  assign wrT1 = wr && paddr == 12'h004;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet; !wr [*3]; endsequence
  sequence s_dacHeld; $stable(dacOut1Enable) [*3]; endsequence
  property p_gain; $onehot0(amp1GainSel) && $onehot0(amp2GainSel); endproperty
  property p_pos; $onehot0(amp1PosInSel); endproperty
  property p_neg; $onehot0({amp1NegInSel, amp1NegGround}); endproperty
  property p_off;
    s_quiet ##0 !amp1Enable |-> {amp1GainSel, amp1PosInSel, amp1NegInSel, amp1NegGround} == '0;
  endproperty
  property p_dac; s_dacHeld |-> dacToPin1Switch == dacOut1Enable; endproperty
  property p_route; !(amp2ToPin1Switch && amp2ToPin2Switch); endproperty
  property p_en; $rose(amp1Enable) |-> $past(wrEn1) || $past(wrEn1, 2); endproperty
  property p_trim; $changed(amp1OffsetTrim) |-> $past(wrT1) || $past(wrT1, 2); endproperty
  property p_rd; psel && penable && !pwrite && paddr == 12'h004 |-> prdata[31:6] == '0; endproperty
  a_gain: assert property (p_gain) else $error("gain select not one-hot");
  a_pos: assert property (p_pos) else $error("positive select not one-hot");
  a_neg: assert property (p_neg) else $error("negative source not exclusive");
  a_off: assert property (p_off) else $error("decoded controls active while off");
  a_dac: assert property (p_dac) else $error("converter switch not following");
  a_route: assert property (p_route) else $error("amp two on both pins");
  a_en: assert property (p_en) else $error("enable rose without write");
  a_trim: assert property (p_trim) else $error("trim changed without write");
  a_rd: assert property (p_rd) else $error("trim upper bits not zero");
endmodule
bind amplifier_gain_input_control amp_ctrl_checker chk (.*);

// ==== dv/testbench.sv ====
// Purpose: directed register tests for the amplifier control block
// Assumes: zero-wait APB slave as described in the hand-over
// Notes:   outputs sampled three edges after most writes; the rest are checked by readback
`include "amp_ctrl_regs.svh"
module testbench
  import amp_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, dacOut1Enable, dacOut2Enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic e, amp1Enable, amp2Enable, amp1NegGround, amp2NegGround;
  logic amp1ToPin1Switch, amp2ToPin1Switch, amp2ToPin2Switch, dacToPin1Switch, dacToPin2Switch;
  gain_oh_t amp1GainSel, amp2GainSel;
  sel_oh_t amp1PosInSel, amp2PosInSel, amp1NegInSel, amp2NegInSel;
  trim_t amp1OffsetTrim, amp2OffsetTrim;
  int mismatches, nChecks, cycles;
  amplifier_gain_input_control DUT (.*);
  always #2.5 clk = ~clk;
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task wrap_up();
    if (mismatches == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic [11:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 0, 0);
    check(r, exp);
  endtask
  task look();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'h3; dacOut1Enable = 0; dacOut2Enable = 0;
    repeat (20) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 5; i++) rd(12'(i * 4), 0);
    xfer(`TRIM2_ADDR, 32'h15, 1);
    look();
    check(32'(amp2OffsetTrim), 32'h15);
    for (int c = 0; c < 8; c++)
    begin
      xfer(`CTRL1_ADDR, 32'h8000 | (c << 11) | (c << 8) | c, 1);
      look();
      check(32'(amp1GainSel), (c > 1 && c < 7) ? 32'h1 << (c - 2) : 0);
      check(32'(amp1PosInSel), c < 4 ? 32'h1 << c : 0);
      check(32'(amp1NegInSel), c < 3 ? 32'h1 << c : 0);
      check(32'(amp1NegGround), 32'(c == 3));
    end
    xfer(`CTRL2_ADDR, 32'h8006, 1);
    look();
    check(32'({amp2Enable, amp2NegGround, amp2GainSel, amp2NegInSel, amp2PosInSel}),
          32'h5011);
    xfer(`CTRL1_ADDR, 32'h1a02, 1);
    look();
    check(32'({amp1Enable, amp1GainSel, amp1PosInSel, amp1NegInSel}), 0);
    xfer(`CTRL1_ADDR, 32'hffffffff, 1);
    rd(`CTRL1_ADDR, 32'hff07);
    xfer(`TRIM1_ADDR, 32'hffffffff, 1);
    rd(`TRIM1_ADDR, 32'h3f);
    check(32'({amp2OffsetTrim, amp1OffsetTrim}), 32'h57f);
    xfer(`CTRL2_ADDR, 32'hc002, 1);
    @(posedge clk);
    dacOut1Enable <= 1;
    dacOut2Enable <= 1;
    look();
    check(32'({amp1ToPin1Switch, amp2ToPin2Switch, amp2ToPin1Switch,
               dacToPin1Switch, dacToPin2Switch}), 32'h1b);
    xfer(`OPTION_ADDR, 1, 1);
    look();
    check(32'({amp1ToPin1Switch, amp2ToPin2Switch, amp2ToPin1Switch}), 32'h5);
    rd(`STATUS_ADDR, 32'h6f);
    rd(`OPTION_ADDR, 32'h1);
    xfer(`CTRL1_ADDR, 32'h8000, 1);
    look();
    check(32'({amp1ToPin1Switch, amp1Enable}), 32'h1);
    rd(`CTRL1_ADDR, 32'h8000);
    pstrb <= 4'h1;
    xfer(`CTRL1_ADDR, 32'hffff, 1);
    pstrb <= 4'h3;
    rd(`CTRL1_ADDR, 32'h8007);
    xfer(12'h020, 32'h1234, 1);
    rd(12'h020, 0);
    check(32'(e), 1);
    wrap_up();
  end
endmodule

// ==== hdl/amp_channel.sv ====
// Purpose: one amplifier instance: control and trim registers, decoded controls
// Assumes: writes come one cycle wide with byte-masked data
// Notes:   decoded outputs are registered and one-hot or all zero
`include "amp_ctrl_regs.svh"
module amp_channel
  import amp_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ctrlWr,
  input  wire logic        trimWr,
  input  wire logic [15:0] wrData,
  output logic [15:0]      ctrlRd,
  output logic [15:0]      trimRd,
  output logic             ampEnable,
  output logic             ampOutputPinEnable,
  output gain_oh_t         gainSel,
  output sel_oh_t          posInSel,
  output sel_oh_t          negInSel,
  output logic             negGround,
  output trim_t            offsetTrim
);
  typedef struct packed {
    logic [15:0] ctrl;
    trim_t       trim;
    logic        en;
    logic        oe;
    gain_oh_t    gain;
    sel_oh_t     pos;
    sel_oh_t     neg;
    logic        gnd;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // --------------------------------------------------------------------------
  // register update and decode
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic [2:0] g;
    logic [2:0] p;
    logic [2:0] n;
    logic       on;
    g  = 3'h0;
    p  = 3'h0;
    n  = 3'h0;
    on = 1'b0;
    st_nxt = st_r;
    if (ctrlWr)
    begin
      st_nxt.ctrl = wrData & `CTRL_MASK;
    end
    if (trimWr)
    begin
      st_nxt.trim = wrData[`TRIM_HI:`TRIM_LO];
    end
    g  = st_nxt.ctrl[`GAIN_HI:`GAIN_LO];
    p  = st_nxt.ctrl[`POS_HI:`POS_LO];
    n  = st_nxt.ctrl[`NEG_HI:`NEG_LO];
    on = st_nxt.ctrl[`ENABLE_BIT];
    st_nxt.en   = on;
    st_nxt.oe   = st_nxt.ctrl[`OUT_EN_BIT];
    st_nxt.gain = '0;
    st_nxt.pos  = '0;
    st_nxt.neg  = '0;
    st_nxt.gnd  = 1'b0;
    if (on && g >= `GAIN_4_CODE && g <= `GAIN_64_CODE)
    begin
      st_nxt.gain[3'(g - `GAIN_4_CODE)] = 1'b1;
    end
    if (on && p <= `POS_MAX_CODE)
    begin
      st_nxt.pos[p[1:0]] = 1'b1;
    end
    if (on && n == `NEG_GND_CODE)
    begin
      st_nxt.gnd = 1'b1;
    end
    else if (on && n <= `NEG_PIN3_CODE)
    begin
      st_nxt.neg[n[1:0]] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r      <= '0;
      st_r.ctrl <= `CTRL_RESET;
      st_r.trim <= `TRIM_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign ctrlRd             = st_r.ctrl;
  assign trimRd             = {10'h000, st_r.trim};
  assign ampEnable          = st_r.en;
  assign ampOutputPinEnable = st_r.oe;
  assign gainSel            = st_r.gain;
  assign posInSel           = st_r.pos;
  assign negInSel           = st_r.neg;
  assign negGround          = st_r.gnd;
  assign offsetTrim         = st_r.trim;
endmodule

// ==== hdl/amplifier_gain_input_control.sv ====
// Purpose: APB register bank and switch control for two gain amplifiers
// Assumes: single clock, zero-wait APB slave
// Notes:   converter output enables come in as inputs and are never arbitrated
//
// Our own choices: the placing of the registers and the APB slave port.
`include "amp_ctrl_regs.svh"
module amplifier_gain_input_control
  import amp_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dacOut1Enable,
  input  wire logic        dacOut2Enable,
  output logic             amp1Enable,
  output logic             amp2Enable,
  output gain_oh_t         amp1GainSel,
  output gain_oh_t         amp2GainSel,
  output sel_oh_t          amp1PosInSel,
  output sel_oh_t          amp2PosInSel,
  output sel_oh_t          amp1NegInSel,
  output sel_oh_t          amp2NegInSel,
  output logic             amp1NegGround,
  output logic             amp2NegGround,
  output trim_t            amp1OffsetTrim,
  output trim_t            amp2OffsetTrim,
  output logic             amp1ToPin1Switch,
  output logic             amp2ToPin1Switch,
  output logic             amp2ToPin2Switch,
  output logic             dacToPin1Switch,
  output logic             dacToPin2Switch
);
  typedef struct packed {
    logic        singlePinRouteOption;
    logic [31:0] rdata;
    logic        slverr;
    logic        sw11;
    logic        sw21;
    logic        sw22;
    logic        dac1;
    logic        dac2;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  logic        access;
  logic        wrEn;
  logic [15:0] wMask;
  logic [15:0] ctrl1Rd;
  logic [15:0] ctrl2Rd;
  logic [15:0] trim1Rd;
  logic [15:0] trim2Rd;
  logic        oe1;
  logic        oe2;
  logic        hit;

  assign access = psel && !penable;
  assign wrEn   = psel && penable && pwrite;
  assign wMask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign hit    = paddr == `CTRL1_ADDR || paddr == `TRIM1_ADDR
               || paddr == `CTRL2_ADDR || paddr == `TRIM2_ADDR
               || paddr == `OPTION_ADDR || paddr == `STATUS_ADDR;

  logic [15:0] wData1;
  logic [15:0] wData2;
  logic [15:0] wDataT1;
  logic [15:0] wDataT2;
  assign wData1  = (pwdata[15:0] & wMask) | (ctrl1Rd & ~wMask);
  assign wData2  = (pwdata[15:0] & wMask) | (ctrl2Rd & ~wMask);
  assign wDataT1 = (pwdata[15:0] & wMask) | (trim1Rd & ~wMask);
  assign wDataT2 = (pwdata[15:0] & wMask) | (trim2Rd & ~wMask);

  // --------------------------------------------------------------------------
  // amplifier instances
  // --------------------------------------------------------------------------
  amp_channel u_amp1 (
    .clk                (clk),
    .rst                (rst),
    .ctrlWr             (wrEn && paddr == `CTRL1_ADDR),
    .trimWr             (wrEn && paddr == `TRIM1_ADDR),
    .wrData             (paddr == `CTRL1_ADDR ? wData1 : wDataT1),
    .ctrlRd             (ctrl1Rd),
    .trimRd             (trim1Rd),
    .ampEnable          (amp1Enable),
    .ampOutputPinEnable (oe1),
    .gainSel            (amp1GainSel),
    .posInSel           (amp1PosInSel),
    .negInSel           (amp1NegInSel),
    .negGround          (amp1NegGround),
    .offsetTrim         (amp1OffsetTrim)
  );

  amp_channel u_amp2 (
    .clk                (clk),
    .rst                (rst),
    .ctrlWr             (wrEn && paddr == `CTRL2_ADDR),
    .trimWr             (wrEn && paddr == `TRIM2_ADDR),
    .wrData             (paddr == `CTRL2_ADDR ? wData2 : wDataT2),
    .ctrlRd             (ctrl2Rd),
    .trimRd             (trim2Rd),
    .ampEnable          (amp2Enable),
    .ampOutputPinEnable (oe2),
    .gainSel            (amp2GainSel),
    .posInSel           (amp2PosInSel),
    .negInSel           (amp2NegInSel),
    .negGround          (amp2NegGround),
    .offsetTrim         (amp2OffsetTrim)
  );

  // --------------------------------------------------------------------------
  // read data, option register and pin routing
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (wrEn && paddr == `OPTION_ADDR && pstrb[0])
    begin
      st_nxt.singlePinRouteOption = pwdata[0];
    end
    if (access)
    begin
      st_nxt.slverr = !hit;
      case (paddr)
        `CTRL1_ADDR:  st_nxt.rdata = {16'h0000, ctrl1Rd};
        `TRIM1_ADDR:  st_nxt.rdata = {16'h0000, trim1Rd};
        `CTRL2_ADDR:  st_nxt.rdata = {16'h0000, ctrl2Rd};
        `TRIM2_ADDR:  st_nxt.rdata = {16'h0000, trim2Rd};
        `OPTION_ADDR: st_nxt.rdata = {31'h0, st_r.singlePinRouteOption};
        `STATUS_ADDR: st_nxt.rdata = {25'h0, st_r.dac2, st_r.dac1, st_r.sw22,
                                      st_r.sw21, st_r.sw11, amp2Enable, amp1Enable};
        default:      st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    st_nxt.sw11 = oe1;
    st_nxt.sw22 = oe2 && !st_r.singlePinRouteOption;
    st_nxt.sw21 = oe2 && st_r.singlePinRouteOption;
    st_nxt.dac1 = dacOut1Enable;
    st_nxt.dac2 = dacOut2Enable;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata           = st_r.rdata;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && st_r.slverr;
  assign amp1ToPin1Switch = st_r.sw11;
  assign amp2ToPin1Switch = st_r.sw21;
  assign amp2ToPin2Switch = st_r.sw22;
  assign dacToPin1Switch  = st_r.dac1;
  assign dacToPin2Switch  = st_r.dac2;
endmodule

// ==== inc/amp_ctrl_pkg.sv ====
// Purpose: types shared by the amplifier control files
// Assumes: none
// Notes:   one-hot widths for the decoded analog controls
package amp_ctrl_pkg;
  typedef logic [4:0] gain_oh_t;
  typedef logic [3:0] sel_oh_t;
  typedef logic [5:0] trim_t;
endpackage

// ==== inc/amp_ctrl_regs.svh ====
`ifndef AMP_CTRL_REGS_SVH
`define AMP_CTRL_REGS_SVH
// ----------------------------------------------------------------------------
// register map, field positions and reset values
// ----------------------------------------------------------------------------
`define CTRL1_ADDR      12'h000
`define TRIM1_ADDR      12'h004
`define CTRL2_ADDR      12'h008
`define TRIM2_ADDR      12'h00c
`define OPTION_ADDR     12'h010
`define STATUS_ADDR     12'h014
`define ENABLE_BIT      15
`define OUT_EN_BIT      14
`define POS_HI          13
`define POS_LO          11
`define NEG_HI          10
`define NEG_LO          8
`define GAIN_HI         2
`define GAIN_LO         0
`define TRIM_HI         5
`define TRIM_LO         0
`define CTRL_MASK       16'hff07
`define TRIM_MASK       16'h003f
`define CTRL_RESET      16'h0000
`define TRIM_RESET      6'h00
`define POS_MAX_CODE    3'h3
`define NEG_GND_CODE    3'h3
`define NEG_PIN2_CODE   3'h1
`define NEG_PIN3_CODE   3'h2
`define NEG_PIN1_CODE   3'h0
`define GAIN_4_CODE     3'h2
`define GAIN_64_CODE    3'h6
`endif
